// >>> bench/rfs_host.sv
// Host controller model: kicks the watchdog line while out of reset
`timescale 1ns/1ps
module rfs_host (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       reset_pin_i,
  input  wire logic       kick_en_i,
  input  wire logic [3:0] half_i,
  output logic            kick_o
);
  logic [3:0] cnt_q;
  // A host held in reset runs no code, so it cannot kick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 4'h0;
      kick_o <= 1'b0;
    end else if (kick_en_i && reset_pin_i) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= half_i) begin
        cnt_q  <= 4'h0;
        kick_o <= ~kick_o;
      end
    end
  end
endmodule // rfs_host

// >>> bench/rfs_sequencer_asserts.sv
// Port checker for the regulator fault sequencer
`timescale 1ns/1ps
module rfs_sequencer_asserts
  import rfs_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire rfs_flags_type flags_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic          smps_enable_o,
  input wire logic          low_rail_enable_o,
  input wire logic          high_rail_enable_o,
  input wire logic          low_rail_limit_o,
  input wire logic          system_reset_out_n_o,
  input wire logic          system_reset_out_n_oe_o,
  input wire logic          ignition_echo_out_o,
  input wire logic          ignition_echo_out_oe_o,
  input wire logic          linear_rail_monitor_out_o,
  input wire logic          linear_rail_monitor_out_oe_o
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Eight cycles of a held flag cover the synchroniser plus two register stages
  a_uv_shutdown: assert property (flags_i.supply_below_stop[*8] |->
    !smps_enable_o && !low_rail_enable_o && system_reset_out_n_oe_o) else $error("uv shutdown");
  a_ov_shutdown: assert property (flags_i.supply_overvoltage[*8] |->
    !smps_enable_o && !high_rail_enable_o && system_reset_out_n_oe_o) else $error("ov shutdown");
  a_ot_shutdown: assert property (flags_i.over_temperature[*8] |->
    !smps_enable_o && !low_rail_enable_o && system_reset_out_n_oe_o) else $error("ot shutdown");
  a_rails_first: assert property ($rose(smps_enable_o) |->
    $past(low_rail_enable_o) && $past(high_rail_enable_o)) else $error("smps before rails");
  a_off_reset_low: assert property (!low_rail_enable_o && !high_rail_enable_o |->
    system_reset_out_n_oe_o) else $error("reset released while off");
  a_echo_released: assert property (flags_i.activation[*8] |->
    !ignition_echo_out_oe_o) else $error("echo pulled with activation high");
  a_monitor_low: assert property (flags_i.low_rail_below_stop[*8] |->
    linear_rail_monitor_out_oe_o) else $error("monitor not pulled");
  a_limit_only: assert property ((flags_i.low_rail_out_of_reg && low_rail_enable_o)[*8] |->
    low_rail_limit_o && low_rail_enable_o) else $error("low rail not limited");
  a_pins_low: assert property (!system_reset_out_n_o && !ignition_echo_out_o &&
    !linear_rail_monitor_out_o) else $error("open-drain level high");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  c_smps_on: cover property ($rose(smps_enable_o));
  c_reset_rel: cover property ($fell(system_reset_out_n_oe_o));
  c_limit: cover property ($rose(low_rail_limit_o));
endmodule // rfs_sequencer_asserts

bind rfs_sequencer rfs_sequencer_asserts u_chk (.clk_i, .rst_i, .flags_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .smps_enable_o, .low_rail_enable_o, .high_rail_enable_o,
  .low_rail_limit_o, .system_reset_out_n_o, .system_reset_out_n_oe_o, .ignition_echo_out_o,
  .ignition_echo_out_oe_o, .linear_rail_monitor_out_o, .linear_rail_monitor_out_oe_o);

// >>> bench/tb_top.sv
// Self-checking bench for the regulator fault sequencer
`timescale 1ns/1ps
module tb_top;
  import rfs_pkg::*;
  localparam int unsigned SS = 20;
  logic          clk_i, rst_i, act, kick_en, kick, cyc, stb, we, ack;
  logic [3:0]    half, adr, sel;
  logic [31:0]   wdat, rdat, d, r;
  rfs_flags_type fl, fi;
  logic          smps, ss, le, he, ll, hl, rn, rn_oe, ig, ig_oe, mon, mon_oe, rpin;
  integer        seed, num_errors, checks;

  rfs_sequencer #(.POR_CYCLES(20), .BOOT_CYCLES(20), .WD_CYCLES(30), .SS_CYCLES(SS)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .flags_i(fi), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .smps_enable_o(smps), .soft_start_o(ss), .low_rail_enable_o(le),
    .high_rail_enable_o(he), .low_rail_limit_o(ll), .high_rail_limit_o(hl),
    .system_reset_out_n_o(rn), .system_reset_out_n_oe_o(rn_oe), .ignition_echo_out_o(ig),
    .ignition_echo_out_oe_o(ig_oe), .linear_rail_monitor_out_o(mon),
    .linear_rail_monitor_out_oe_o(mon_oe));
  rfs_host u_host (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_i(rpin), .kick_en_i(kick_en),
    .half_i(half), .kick_o(kick));

  assign rpin = rn_oe ? rn : 1'b1;
  always_comb begin
    fi = fl;
    fi.activation = act;
    fi.watchdog_kick_in = kick;
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    d = rdat;
    chk("wb_ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  // Outputs packed as switcher, low rail, high rail, reset pull
  function automatic logic [3:0] outs_exp(input logic on, input logic rails, input logic rl);
    return {on, rails, rails, rl};
  endfunction
  task automatic outs(input logic [3:0] e);
    chk("outputs", {smps, le, he, rn_oe}, e);
  endtask
  task automatic rel(input logic v);
    int t;
    t = 0;
    while (rn_oe !== v && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    chk("reset_oe", rn_oe, v);
  endtask
  task automatic results;
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    seed = 32'h3D06A561;
    num_errors = 0;
    checks = 0;
    rst_i = 1'b1;
    fl = '0;
    act = 1'b0;
    kick_en = 1'b0;
    half = 4'h4;
    {cyc, stb, we, adr, wdat, sel} = '0;
    cy(20);
    rst_i <= 1'b0;
    outs(outs_exp(0, 0, 1));
    wb(0, CTRL_ADDR, 32'h0);
    chk("ctrl_rst", d, {24'h0, CTRL_RESET_VAL});
    wb(1, 4'h8, 32'hFFFF_FFFF);
    wb(0, 4'h8, 32'h0);
    chk("unmapped", d, 32'h0);
    fl.supply_above_start <= 1'b1;
    cy(12);
    outs(outs_exp(0, 0, 1));
    act <= 1'b1;
    kick_en <= 1'b1;
    fl.smps_reg_ok <= 1'b1;
    cy(12);
    outs(outs_exp(0, 1, 1));
    fl.low_rail_above_start <= 1'b1;
    fl.high_rail_above_start <= 1'b1;
    cy(8);
    act <= 1'b0;
    cy(8);
    outs(outs_exp(1, 1, 1));
    chk("soft_start", ss, 1'b1);
    chk("echo_low", ig_oe, 1'b1);
    act <= 1'b1;
    rel(0);
    chk("soft_start_end", ss, 1'b0);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      if (i == 0) r[2:0] = 3'b111;
      fl.low_rail_out_of_reg <= r[0];
      fl.high_rail_out_of_reg <= r[1];
      fl.low_rail_below_stop <= r[2];
      half <= {2'b00, r[5:4]} + 4'h2;
      wb(1, CTRL_ADDR, r | 32'h1);
      wb(0, CTRL_ADDR, 32'h0);
      chk("ctrl", d, {24'h0, r[7:1], 1'b1});
      cy(8);
      chk("limits", {ll, hl}, {r[0], r[1]});
      outs(outs_exp(1, 1, 0));
      chk("monitor", mon_oe, r[2]);
      chk("echo_high", ig_oe, 1'b0);
    end
    fl.low_rail_out_of_reg <= 1'b0;
    fl.high_rail_out_of_reg <= 1'b0;
    fl.low_rail_below_stop <= 1'b0;
    kick_en <= 1'b0;
    rel(1);
    outs(outs_exp(1, 1, 1));
    kick_en <= 1'b1;
    rel(0);
    act <= 1'b0;
    fl.over_temperature <= 1'b1;
    cy(10);
    outs(outs_exp(0, 0, 1));
    fl.over_temperature <= 1'b0;
    cy(12);
    chk("rails_ot", {le, he}, 2'b11);
    cy(SS + 10);
    fl.smps_reg_ok <= 1'b0;
    fl.smps_reg_low <= 1'b1;
    cy(12);
    outs(outs_exp(0, 0, 1));
    chk("echo_unlatched", ig_oe, 1'b0);
    fl.smps_reg_ok <= 1'b1;
    fl.smps_reg_low <= 1'b0;
    act <= 1'b1;
    rel(0);
    fl.smps_reg_ok <= 1'b0;
    fl.smps_reg_low <= 1'b1;
    cy(12);
    outs(outs_exp(1, 1, 1));
    fl.smps_reg_ok <= 1'b1;
    fl.smps_reg_low <= 1'b0;
    rel(0);
    act <= 1'b0;
    fl.supply_overvoltage <= 1'b1;
    cy(10);
    outs(outs_exp(0, 0, 1));
    fl.supply_overvoltage <= 1'b0;
    cy(12);
    chk("rails_ov", {le, he}, 2'b11);
    act <= 1'b1;
    cy(SS + 10);
    fl.smps_short <= 1'b1;
    cy(10);
    fl.smps_short <= 1'b0;
    cy(10);
    outs(outs_exp(0, 1, 1));
    act <= 1'b0;
    cy(10);
    outs(outs_exp(0, 0, 1));
    act <= 1'b1;
    cy(12);
    chk("restart", le, 1'b1);
    fl.supply_below_stop <= 1'b1;
    cy(10);
    outs(outs_exp(0, 0, 1));
    results;
  end

  initial begin
    cy(8000);
    num_errors++;
    results;
  end
endmodule // tb_top

// >>> rtl/rfs_pkg.sv
// Package for the regulator fault sequencer: constants, flag carrier, states
package rfs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned POR_DELAY_US      = 5000;
  localparam int unsigned BOOT_DELAY_US     = 50000;
  localparam int unsigned WATCHDOG_TIMEOUT_US = 60000;
  localparam int unsigned SOFT_START_US     = 2000;
  localparam int unsigned POR_CYCLES_DFLT   = POR_DELAY_US * CLK_MHZ;
  localparam int unsigned BOOT_CYCLES_DFLT  = BOOT_DELAY_US * CLK_MHZ;
  localparam int unsigned WD_CYCLES_DFLT    = WATCHDOG_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned SS_CYCLES_DFLT    = SOFT_START_US * CLK_MHZ;
  localparam int unsigned TIMER_W           = 32;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned WB_ADR_W          = 4;
  localparam logic [3:0]  CTRL_ADDR         = 4'h0;
  localparam logic [3:0]  STATUS_ADDR       = 4'h4;
  localparam int unsigned CTRL_WD_EN_BIT    = 0;
  localparam logic [7:0]  CTRL_RESET_VAL    = 8'h01;
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_PHASE_LSB    = 4;
  localparam int unsigned STAT_LATCH_BIT    = 8;
  localparam int unsigned STAT_FLAGS_LSB    = 16;

  // ==========================================================================
  // Comparator flags, all asynchronous to clk_i
  // ==========================================================================
  typedef struct packed {
    logic supply_above_start;   // supply above supply_start_threshold
    logic supply_below_stop;    // supply below supply_stop_threshold
    logic supply_overvoltage;   // set at overvoltage_stop_threshold, clears at restart
    logic over_temperature;
    logic low_rail_above_start; // low_rail_uv_start_level reached
    logic high_rail_above_start;// high_rail_uv_start_level reached
    logic low_rail_below_stop;  // below low_rail_uv_stop_level
    logic low_rail_out_of_reg;
    logic high_rail_out_of_reg;
    logic smps_reg_low;         // feedback below low monitor level
    logic smps_reg_ok;          // feedback above high monitor level
    logic smps_short;
    logic activation;           // enable input level
    logic watchdog_kick_in;
  } rfs_flags_type;

  localparam int unsigned FLAGS_W = $bits(rfs_flags_type);

  // ==========================================================================
  // States
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_OFF        = 3'b000,
    ST_STANDBY    = 3'b001,
    ST_RAILS_UP   = 3'b010,
    ST_SOFT_START = 3'b011,
    ST_RUN        = 3'b100,
    ST_FAULT      = 3'b101,
    ST_SHORT_OFF  = 3'b110
  } rfs_state_type;

  typedef enum logic [1:0] {
    RP_HOLD  = 2'b00,
    RP_POR   = 2'b01,
    RP_BOOT  = 2'b10,
    RP_WATCH = 2'b11
  } rfs_phase_type;

endpackage

// >>> rtl/rfs_sequencer.sv
// Regulator fault sequencer: rail/switcher control, reset and watchdog timing
`timescale 1ns/1ps
// Operation
// - Supply above start, no activation high seen yet: hold system reset low.
// - Supply below stop: reset low, switcher and both rails off, latch cleared.
// - Overvoltage: reset low, switcher off, soft-start reset, rails off, latch kept.
// - Overvoltage cleared: rails up and soft-start regardless of activation.
// - Over-temperature: switcher off, soft-start reset, rails off, reset low, latch kept.
// - Over-temperature cleared: resume automatically regardless of activation.
// - Activation low after supply start: standby, everything off, reset low.
// - Activation high: rails on first, switcher soft-start afterwards.
// - After a rail regulates, activation low ignored until soft-start expiry.
// - After expiry, activation low plus regulation loss or watchdog timeout: standby.
// - Echo pin pulled low while latched activation is low, released when high.
// - Activation not latched: echo pin no longer driven once activation falls.
// - Soft-start waits until at least one rail passes its start level.
// - Rail monitor pin low while low-voltage rail is below its stop level.
// - Rail out of regulation: that rail current-limits only, nothing else changes.
// - Switcher unregulated: activation low shuts down; high holds reset low only.
// - Switcher short: high latches switcher off, rails on; low shuts down.
// - Watchdog timeout with activation high: re-enter power-on delay, outputs run.
// - Switcher low: reset low, delays reinitialised; power-on delay on recovery.
module rfs_sequencer
  import rfs_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = POR_CYCLES_DFLT,
  parameter int unsigned BOOT_CYCLES = BOOT_CYCLES_DFLT,
  parameter int unsigned WD_CYCLES   = WD_CYCLES_DFLT,
  parameter int unsigned SS_CYCLES   = SS_CYCLES_DFLT
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire rfs_flags_type       flags_i,
  // Wishbone classic slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Regulator controls
  output logic                     smps_enable_o,
  output logic                     soft_start_o,
  output logic                     low_rail_enable_o,
  output logic                     high_rail_enable_o,
  output logic                     low_rail_limit_o,
  output logic                     high_rail_limit_o,
  // Open-drain pins: level is always low, enable pulls the pin
  output logic                     system_reset_out_n_o,
  output logic                     system_reset_out_n_oe_o,
  output logic                     ignition_echo_out_o,
  output logic                     ignition_echo_out_oe_o,
  output logic                     linear_rail_monitor_out_o,
  output logic                     linear_rail_monitor_out_oe_o
);

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  rfs_flags_type f;
  logic [FLAGS_W-1:0] f_bits;

  rfs_sync #(
    .WIDTH (FLAGS_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (flags_i),
    .sync_o  (f_bits)
  );

  assign f = rfs_flags_type'(f_bits);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  rfs_state_type      state_q;
  rfs_state_type      state_d;
  rfs_phase_type      phase_q;
  logic               latch_q;
  logic               latch_d;
  logic [TIMER_W-1:0] ss_cnt_q;
  logic [TIMER_W-1:0] dly_cnt_q;
  logic               kick_q;
  logic               kick_fall;
  logic               wd_timeout;
  logic               ss_expired;
  logic               shutdown_fault;
  logic [7:0]         ctrl_q;
  logic               wd_en;

  // A kick edge in the timeout cycle still counts, so a late host is not reset
  assign kick_fall      = kick_q & ~f.watchdog_kick_in;
  assign ss_expired     = (ss_cnt_q >= TIMER_W'(SS_CYCLES));
  assign shutdown_fault = f.supply_overvoltage | f.over_temperature;
  assign wd_en          = ctrl_q[CTRL_WD_EN_BIT];
  assign wd_timeout     = wd_en && (phase_q == RP_WATCH)
                          && (dly_cnt_q >= TIMER_W'(WD_CYCLES - 1)) && !kick_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= f.watchdog_kick_in;
    end
  end

  // ==========================================================================
  // Main state machine
  // ==========================================================================
  // Supply loss outranks every other fault; overvoltage and heat keep the latch
  always_comb begin
    state_d = state_q;
    latch_d = latch_q;
    if (!f.supply_above_start || f.supply_below_stop) begin
      state_d = ST_OFF;
      latch_d = 1'b0;
    end else if (shutdown_fault) begin
      state_d = ST_FAULT;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_d = ST_STANDBY;
        end
        ST_STANDBY: begin
          if (f.activation) begin
            state_d = ST_RAILS_UP;
            latch_d = 1'b1;
          end
        end
        ST_FAULT: begin
          state_d = ST_RAILS_UP;
        end
        ST_RAILS_UP: begin
          if (f.low_rail_above_start || f.high_rail_above_start) begin
            state_d = ST_SOFT_START;
          end else if (!f.activation && !latch_q) begin
            state_d = ST_STANDBY;
          end
        end
        ST_SOFT_START: begin
          // Activation is not looked at here at all
          if (ss_expired) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (f.smps_short) begin
            latch_d = 1'b0;
            state_d = f.activation ? ST_SHORT_OFF : ST_STANDBY;
          end else if (!f.activation && (f.smps_reg_low || wd_timeout)) begin
            state_d = ST_STANDBY;
            latch_d = 1'b0;
          end
        end
        ST_SHORT_OFF: begin
          // Restart needs activation to fall first, then rise through standby
          if (!f.activation) begin
            state_d = ST_STANDBY;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
      latch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      latch_q <= latch_d;
    end
  end

  // ==========================================================================
  // Soft-start timer
  // ==========================================================================
  // Cleared in any state other than soft-start/run so faults restart the ramp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cnt_q <= '0;
    end else if (state_q != ST_SOFT_START && state_q != ST_RUN) begin
      ss_cnt_q <= '0;
    end else if (!ss_expired) begin
      ss_cnt_q <= ss_cnt_q + TIMER_W'(1);
    end
  end

  // ==========================================================================
  // Power-on, boot and watchdog delays
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q   <= RP_HOLD;
      dly_cnt_q <= '0;
    end else if (state_q != ST_RUN || f.smps_reg_low) begin
      phase_q   <= RP_HOLD;
      dly_cnt_q <= '0;
    end else begin
      unique case (phase_q)
        RP_HOLD: begin
          if (f.smps_reg_ok) begin
            phase_q   <= RP_POR;
            dly_cnt_q <= '0;
          end
        end
        RP_POR: begin
          if (dly_cnt_q >= TIMER_W'(POR_CYCLES - 1)) begin
            phase_q   <= RP_BOOT;
            dly_cnt_q <= '0;
          end else begin
            dly_cnt_q <= dly_cnt_q + TIMER_W'(1);
          end
        end
        RP_BOOT: begin
          if (dly_cnt_q >= TIMER_W'(BOOT_CYCLES - 1)) begin
            phase_q   <= RP_WATCH;
            dly_cnt_q <= '0;
          end else begin
            dly_cnt_q <= dly_cnt_q + TIMER_W'(1);
          end
        end
        RP_WATCH: begin
          if (kick_fall || !wd_en) begin
            dly_cnt_q <= '0;
          end else if (wd_timeout) begin
            phase_q   <= RP_POR;
            dly_cnt_q <= '0;
          end else begin
            dly_cnt_q <= dly_cnt_q + TIMER_W'(1);
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Both rails share one enable; only the limit outputs tell them apart
  logic rails_on;
  logic rst_release;

  assign rails_on = (state_q == ST_RAILS_UP) || (state_q == ST_SOFT_START)
                    || (state_q == ST_RUN) || (state_q == ST_SHORT_OFF);
  // Reset only released in boot/watch phases of full operation
  assign rst_release = (state_q == ST_RUN)
                       && ((phase_q == RP_BOOT) || (phase_q == RP_WATCH));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smps_enable_o      <= 1'b0;
      soft_start_o       <= 1'b0;
      low_rail_enable_o  <= 1'b0;
      high_rail_enable_o <= 1'b0;
    end else begin
      smps_enable_o      <= (state_q == ST_SOFT_START) || (state_q == ST_RUN);
      soft_start_o       <= (state_q == ST_SOFT_START);
      low_rail_enable_o  <= rails_on;
      high_rail_enable_o <= rails_on;
    end
  end

  // Rail overload only limits that rail; nothing else above looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_rail_limit_o  <= 1'b0;
      high_rail_limit_o <= 1'b0;
    end else begin
      low_rail_limit_o  <= rails_on & f.low_rail_out_of_reg;
      high_rail_limit_o <= rails_on & f.high_rail_out_of_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_reset_out_n_o         <= 1'b0;
      system_reset_out_n_oe_o      <= 1'b1;
      ignition_echo_out_o          <= 1'b0;
      ignition_echo_out_oe_o       <= 1'b0;
      linear_rail_monitor_out_o    <= 1'b0;
      linear_rail_monitor_out_oe_o <= 1'b0;
    end else begin
      system_reset_out_n_o         <= 1'b0;
      system_reset_out_n_oe_o      <= ~rst_release;
      ignition_echo_out_o          <= 1'b0;
      ignition_echo_out_oe_o       <= latch_q & ~f.activation;
      linear_rail_monitor_out_o    <= 1'b0;
      linear_rail_monitor_out_oe_o <= f.low_rail_below_stop;
    end
  end

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  // One wait state: ack in the cycle after the strobe, dropped the next cycle
  logic        wb_req;
  logic [31:0] status_word;

  // Unmapped offsets are acknowledged and read as zero so a master never hangs
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    status_word = '0;
    status_word[STAT_STATE_LSB +: 3]        = state_q;
    status_word[STAT_PHASE_LSB +: 2]        = phase_q;
    status_word[STAT_LATCH_BIT]             = latch_q;
    status_word[STAT_FLAGS_LSB +: FLAGS_W]  = f_bits;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET_VAL;
    // The write lands on the edge where the master sees ack, request still held
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == CTRL_ADDR) begin
      ctrl_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          CTRL_ADDR:   wb_dat_o <= {24'h000000, ctrl_q};
          STATUS_ADDR: wb_dat_o <= status_word;
          default:     wb_dat_o <= '0;
        endcase
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

endmodule // rfs_sequencer

// >>> rtl/rfs_sync.sv
// Three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module rfs_sync
  import rfs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          sync_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule // rfs_sync
